// file: pwc_cfg.svh
// Constants for the power-down wake-up control block.
// Operation
// - Writing one clears wake status flag.
// - Wake status flag acts only when enabled.
// - Wake interrupt enable gates the interrupt.
// - Interrupt high while flag and enable high; the code also needs irq_sts_reg and irq_mask_reg high.
// - Wake-up holds system clock for delay.
// - Crystal source delay is 4096 cycles.
// - Internal RC source delay is 256 cycles.
// - Delay enable bit turns delay on.
// - Any wake-up event sets status flag; the code sets it only for a wake event seen in power-down.
// - Wake-up clears the power-down request bit.
`ifndef PWC_CFG_SVH
`define PWC_CFG_SVH
`define PWC_OFS_POWER_CONTROL 8'h00
`define PWC_OFS_WRITE_PROTECT 8'h04
`define PWC_OFS_IRQ_STATUS    8'h08
`define PWC_OFS_IRQ_CLEAR     8'h0c
`define PWC_OFS_IRQ_ENABLE    8'h10
`define PWC_BIT_DELAY_EN      4
`define PWC_BIT_IRQ_EN        5
`define PWC_BIT_WAKE_STS      6
`define PWC_BIT_PD_REQ        7
`define PWC_KEY_1             8'h59
`define PWC_KEY_2             8'h16
`define PWC_KEY_3             8'h88
`define PWC_DELAY_XTAL        4096
`define PWC_DELAY_RC          13'h0100
`endif

// file: pwc_pkg.sv
// Types for the power-down wake-up control block.
package pwc_pkg;
  typedef enum logic [1:0] {
    PWC_RUN   = 2'b00,
    PWC_DOWN  = 2'b01,
    PWC_DELAY = 2'b11
  } pwc_state_type;
  typedef enum logic [1:0] {
    PWC_KEY_IDLE = 2'b00,
    PWC_KEY_ONE  = 2'b01,
    PWC_KEY_TWO  = 2'b11
  } pwc_key_type;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pwc_bus_type;
endpackage

// file: pwc_top.sv
// Power-down wake-up control with protected control bits and wake delay.
`timescale 1ns/1ps
`include "pwc_cfg.svh"
module pwc_top import pwc_pkg::*; #(
  parameter logic [12:0] XTAL_DELAY = 13'(`PWC_DELAY_XTAL)
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire pwc_bus_type bus,
  output logic [31:0]      rdata,
  input  wire logic        wake_event,
  input  wire logic        clk_src_xtal,
  output logic             powerdown_active,
  output logic             sys_clk_gate,
  output logic             irq
);
  // ---------------------------------------------------------------
  // Reset and input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic [1:0] wake_sync_reg;
  logic [1:0] src_sync_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_sync_reg <= 2'b00;
      src_sync_reg  <= 2'b00;
    end else begin
      wake_sync_reg <= {wake_sync_reg[0], wake_event};
      src_sync_reg  <= {src_sync_reg[0], clk_src_xtal};
    end
  end
  // ---------------------------------------------------------------
  // Write protection unlock
  // ---------------------------------------------------------------
  pwc_key_type key_reg;
  logic        unlocked_reg;
  logic        wr_ctl;
  logic        wr_key;
  assign wr_ctl = bus.wr && (bus.addr == `PWC_OFS_POWER_CONTROL);
  assign wr_key = bus.wr && (bus.addr == `PWC_OFS_WRITE_PROTECT);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      key_reg      <= PWC_KEY_IDLE;
      unlocked_reg <= 1'b0;
    end else if (wr_key) begin
      unlocked_reg <= 1'b0;
      key_reg      <= PWC_KEY_IDLE;
      case (key_reg)
        PWC_KEY_IDLE: begin
          if (bus.wdata[7:0] == `PWC_KEY_1) key_reg <= PWC_KEY_ONE;
        end
        PWC_KEY_ONE: begin
          if (bus.wdata[7:0] == `PWC_KEY_2) key_reg <= PWC_KEY_TWO;
        end
        PWC_KEY_TWO: begin
          if (bus.wdata[7:0] == `PWC_KEY_3) unlocked_reg <= 1'b1;
        end
        default: key_reg <= PWC_KEY_IDLE;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // Power control bits
  // ---------------------------------------------------------------
  logic          irq_en_reg;
  logic          delay_en_reg;
  logic          pd_req_reg;
  logic          wake_sts_reg;
  logic          wake_hit;
  pwc_state_type state_reg;
  logic [12:0]   count_reg;
  assign wake_hit = (state_reg == PWC_DOWN) && wake_sync_reg[1];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_reg   <= 1'b0;
      delay_en_reg <= 1'b0;
    end else if (wr_ctl && unlocked_reg) begin
      irq_en_reg   <= bus.wdata[`PWC_BIT_IRQ_EN];
      delay_en_reg <= bus.wdata[`PWC_BIT_DELAY_EN];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pd_req_reg <= 1'b0;
    end else if (wake_hit) begin
      pd_req_reg <= 1'b0;
    end else if (wr_ctl && unlocked_reg) begin
      pd_req_reg <= bus.wdata[`PWC_BIT_PD_REQ];
    end
  end
  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_sts_reg <= 1'b0;
    end else if (wake_hit) begin
      wake_sts_reg <= 1'b1;
    end else if (wr_ctl && bus.wdata[`PWC_BIT_WAKE_STS]) begin
      wake_sts_reg <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // Power-down and wake delay sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PWC_RUN;
      count_reg <= 13'h0000;
    end else begin
      case (state_reg)
        PWC_RUN: begin
          if (pd_req_reg) state_reg <= PWC_DOWN;
        end
        PWC_DOWN: begin
          if (wake_sync_reg[1]) begin
            if (delay_en_reg) begin
              state_reg <= PWC_DELAY;
              count_reg <= src_sync_reg[1] ? XTAL_DELAY - 13'h0001
                                           : `PWC_DELAY_RC - 13'h0001;
            end else begin
              state_reg <= PWC_RUN;
            end
          end
        end
        PWC_DELAY: begin
          if (count_reg == 13'h0000) begin
            state_reg <= PWC_RUN;
          end else begin
            count_reg <= count_reg - 13'h0001;
          end
        end
        default: state_reg <= PWC_RUN;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      powerdown_active <= 1'b0;
      sys_clk_gate     <= 1'b0;
    end else begin
      powerdown_active <= (state_reg == PWC_DOWN);
      sys_clk_gate     <= (state_reg != PWC_RUN);
    end
  end
  // ---------------------------------------------------------------
  // Interrupt status, clear and enable
  // ---------------------------------------------------------------
  logic irq_sts_reg;
  logic irq_mask_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_sts_reg <= 1'b0;
    end else if (wake_hit) begin
      irq_sts_reg <= 1'b1;
    end else if (bus.wr && (bus.addr == `PWC_OFS_IRQ_CLEAR) && bus.wdata[0]) begin
      irq_sts_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= 1'b1;
    end else if (bus.wr && (bus.addr == `PWC_OFS_IRQ_ENABLE)) begin
      irq_mask_reg <= bus.wdata[0];
    end
  end
  // The flag reaches the line only through its enable, irq_sts_reg and irq_mask_reg.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= wake_sts_reg && irq_en_reg && irq_sts_reg && irq_mask_reg;
    end
  end
  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      rdata <= 32'h0000_0000;
      if (bus.addr == `PWC_OFS_POWER_CONTROL) begin
        rdata[`PWC_BIT_PD_REQ]   <= pd_req_reg;
        rdata[`PWC_BIT_WAKE_STS] <= wake_sts_reg;
        rdata[`PWC_BIT_IRQ_EN]   <= irq_en_reg;
        rdata[`PWC_BIT_DELAY_EN] <= delay_en_reg;
      end else if (bus.addr == `PWC_OFS_WRITE_PROTECT) begin
        rdata[0] <= unlocked_reg;
      end else if (bus.addr == `PWC_OFS_IRQ_STATUS) begin
        rdata[0] <= irq_sts_reg;
      end else if (bus.addr == `PWC_OFS_IRQ_ENABLE) begin
        rdata[0] <= irq_mask_reg;
      end
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_wake_with_delay;
    state_reg == PWC_DOWN && wake_sync_reg[1] && delay_en_reg;
  endsequence
  sequence s_back_to_run;
    ##256 state_reg == PWC_DELAY ##1 state_reg == PWC_RUN;
  endsequence
  sequence s_wake_no_delay;
    state_reg == PWC_DOWN && wake_sync_reg[1] && !delay_en_reg;
  endsequence
  sequence s_power_down_req;
    state_reg == PWC_RUN && pd_req_reg;
  endsequence
  a_locked_write_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_ctl && !unlocked_reg) |=> $stable(irq_en_reg) && $stable(delay_en_reg))
    else $error("Protected bit changed while locked.");
  a_clear_status_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_ctl && bus.wdata[`PWC_BIT_WAKE_STS] && !wake_hit) |=> !wake_sts_reg)
    else $error("Wake status not cleared by write one.");
  a_keep_status_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!wake_hit && !(wr_ctl && bus.wdata[`PWC_BIT_WAKE_STS])) |=> $stable(wake_sts_reg))
    else $error("Wake status changed without cause.");
  a_irq_level_match: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq == $past(wake_sts_reg && irq_en_reg && irq_sts_reg && irq_mask_reg))
    else $error("Interrupt level does not match flag and enable.");
  a_irq_needs_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !irq_en_reg |=> !irq)
    else $error("Interrupt raised while disabled.");
  a_wake_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wake_hit |=> wake_sts_reg && !pd_req_reg)
    else $error("Wake-up did not set flag or clear request.");
  a_rc_delay_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_wake_with_delay and !src_sync_reg[1]) |-> s_back_to_run)
    else $error("Internal RC wake delay has wrong length.");
  a_no_delay_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == PWC_DOWN && wake_sync_reg[1] && !delay_en_reg) |=> state_reg == PWC_RUN)
    else $error("Delay applied while disabled.");
  a_xtal_delay_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_wake_with_delay and src_sync_reg[1]) |=> count_reg == XTAL_DELAY - 13'h0001)
    else $error("Crystal wake delay loaded wrongly.");
  a_clock_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == PWC_DELAY) |=> sys_clk_gate)
    else $error("System clock not held during delay.");
  // ---------------------------------------------------------------
  // Assertions on unlock, gating and read-back
  // ---------------------------------------------------------------
  a_unlock_after_keys: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_key && key_reg == PWC_KEY_TWO && bus.wdata[7:0] == `PWC_KEY_3) |=> unlocked_reg)
    else $error("Protection not unlocked by the key sequence.");
  // Any key write that does not finish the sequence locks again.
  a_key_write_relocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_key && !(key_reg == PWC_KEY_TWO && bus.wdata[7:0] == `PWC_KEY_3)) |=> !unlocked_reg)
    else $error("Protection left unlocked after a wrong key.");
  a_pd_req_locked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_ctl && !unlocked_reg && !wake_hit) |=> $stable(pd_req_reg))
    else $error("Power-down request changed while locked.");
  a_irq_enable_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_ctl && unlocked_reg) |=> irq_en_reg == $past(bus.wdata[`PWC_BIT_IRQ_EN]))
    else $error("Interrupt enable not written while unlocked.");
  a_delay_enable_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_ctl && unlocked_reg) |=> delay_en_reg == $past(bus.wdata[`PWC_BIT_DELAY_EN]))
    else $error("Delay enable not written while unlocked.");
  a_irq_off_no_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !wake_sts_reg |=> !irq)
    else $error("Interrupt raised without wake status.");
  a_irq_mask_gates: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !irq_mask_reg |=> !irq)
    else $error("Interrupt raised while masked.");
  a_enter_down: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_power_down_req |=> state_reg == PWC_DOWN)
    else $error("Power-down request did not enter power-down.");
  a_down_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == PWC_DOWN) |=> powerdown_active && sys_clk_gate)
    else $error("Power-down outputs not raised.");
  a_run_no_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == PWC_RUN) |=> !sys_clk_gate)
    else $error("System clock held while running.");
  // The delay state lasts one cycle per count from N-1 down to 0.
  a_delay_counts_down: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == PWC_DELAY && count_reg != 13'h0000) |=>
      (state_reg == PWC_DELAY && count_reg == $past(count_reg) - 13'h0001))
    else $error("Wake delay counter did not step down.");
  a_delay_end_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == PWC_DELAY && count_reg == 13'h0000) |=>
      state_reg == PWC_RUN ##1 !sys_clk_gate)
    else $error("Wake delay did not release the clock.");
  a_no_delay_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_wake_no_delay |=> state_reg == PWC_RUN ##1 !sys_clk_gate)
    else $error("Clock held after wake-up without delay.");
  a_rc_delay_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_wake_with_delay and !src_sync_reg[1]) |=> count_reg == `PWC_DELAY_RC - 13'h0001)
    else $error("Internal RC wake delay loaded wrongly.");
  a_ctl_read_back: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (bus.rd && bus.addr == `PWC_OFS_POWER_CONTROL) |=>
      rdata[`PWC_BIT_WAKE_STS] == $past(wake_sts_reg))
    else $error("Wake status read back wrongly.");
endmodule // pwc_top

// file: tb_pwc_top.sv
// Self-checking testbench for the power-down wake-up control block.
`timescale 1ns/1ps
`include "pwc_cfg.svh"
module tb_pwc_top import pwc_pkg::*;;
  localparam int XTAL_D = 16;
  logic        clk_sys      = 1'b0;
  logic        reset_n      = 1'b0;
  pwc_bus_type bus          = '0;
  logic        wake_event   = 1'b0;
  logic        clk_src_xtal = 1'b0;
  logic        rd_d         = 1'b0;
  logic [31:0] seed         = 32'h0001139b;
  logic [31:0] rdata;
  logic        powerdown_active;
  logic        sys_clk_gate;
  logic        irq;
  logic [31:0] exp_q[$];
  int          err_total    = 0;
  int          checks_done  = 0;

  pwc_top #(.XTAL_DELAY(13'(XTAL_D))) u_pwc_top (
    .clk_sys          (clk_sys),
    .reset_n          (reset_n),
    .bus              (bus),
    .rdata            (rdata),
    .wake_event       (wake_event),
    .clk_src_xtal     (clk_src_xtal),
    .powerdown_active (powerdown_active),
    .sys_clk_gate     (sys_clk_gate),
    .irq              (irq)
  );

  always #50 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_op(input logic [7:0] a, input logic [31:0] d, input logic w, input logic r);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge clk_sys);
    bus <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_op(a, d, 1'b1, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus_op(a, 32'h0, 1'b0, 1'b1);
  endtask

  // Upper key bits are random because only the low byte is compared.
  task automatic key(input logic [7:0] k);
    seed = xorshift(seed);
    wr(`PWC_OFS_WRITE_PROTECT, {seed[31:8], k});
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Read data monitor
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    rd_d <= bus.rd;
    if (rd_d) begin
      if (exp_q.size() == 0)
        chk(rdata, 32'hffffffff);
      else
        chk(rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0]  ctl_tab[3];
    logic        src_tab[3];
    logic [31:0] keep;
    logic [31:0] gap;
    int          k;
    ctl_tab = '{8'hb0, 8'h90, 8'ha0};
    src_tab = '{1'b1, 1'b0, 1'b1};
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(`PWC_OFS_POWER_CONTROL, 32'h0);
    rd(`PWC_OFS_WRITE_PROTECT, 32'h0);
    rd(`PWC_OFS_IRQ_STATUS, 32'h0);
    rd(`PWC_OFS_IRQ_ENABLE, 32'h1);
    rd(8'h20, 32'h0);
    wr(`PWC_OFS_POWER_CONTROL, 32'hb0);
    rd(`PWC_OFS_POWER_CONTROL, 32'h0);
    key(`PWC_KEY_1);
    key(8'h00);
    key(`PWC_KEY_3);
    rd(`PWC_OFS_WRITE_PROTECT, 32'h0);
    for (int i = 0; i < 3; i++) begin
      clk_src_xtal <= src_tab[i];
      keep = {24'h0, ctl_tab[i] & 8'h30};
      key(`PWC_KEY_1);
      key(`PWC_KEY_2);
      key(`PWC_KEY_3);
      rd(`PWC_OFS_WRITE_PROTECT, 32'h1);
      wr(`PWC_OFS_POWER_CONTROL, {24'h0, ctl_tab[i]});
      repeat (4) @(posedge clk_sys);
      chk({30'h0, powerdown_active, sys_clk_gate}, 32'h3);
      wake_event <= 1'b1;
      for (k = 0; k < 50 && powerdown_active !== 1'b0; k++) @(posedge clk_sys);
      wake_event <= 1'b0;
      chk({31'h0, powerdown_active}, 32'h0);
      for (k = 0; k < 1000 && sys_clk_gate !== 1'b0; k++) @(posedge clk_sys);
      gap = !ctl_tab[i][4] ? 32'h0 : src_tab[i] ? 32'(XTAL_D) : 32'(`PWC_DELAY_RC);
      chk(32'(k), gap);
      rd(`PWC_OFS_POWER_CONTROL, keep | 32'h40);
      rd(`PWC_OFS_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, {31'h0, ctl_tab[i][5]});
      if (i == 0) begin
        wr(`PWC_OFS_IRQ_ENABLE, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        wr(`PWC_OFS_IRQ_ENABLE, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        wr(`PWC_OFS_IRQ_CLEAR, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
      end
      wr(`PWC_OFS_POWER_CONTROL, keep);
      rd(`PWC_OFS_POWER_CONTROL, keep | 32'h40);
      wr(`PWC_OFS_POWER_CONTROL, keep | 32'h40);
      rd(`PWC_OFS_POWER_CONTROL, keep);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
    end
    wake_event <= 1'b1;
    repeat (6) @(posedge clk_sys);
    wake_event <= 1'b0;
    rd(`PWC_OFS_POWER_CONTROL, 32'h20);
    key(8'h00);
    wr(`PWC_OFS_POWER_CONTROL, 32'h10);
    rd(`PWC_OFS_POWER_CONTROL, 32'h20);
    repeat (4) @(posedge clk_sys);
    report_and_stop();
  end
endmodule // tb_pwc_top
